// [dv/testbench.sv]
// self-checking bench for the zvs tuning and dead-time core
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import zdt_pkg::*;
    typedef struct {
        logic [9:0] line;
        logic [7:0] tzmin;
        logic slow;
        int tz;
    } zdt_row_t;
    localparam int NROW = 6;
    zdt_row_t rows [NROW] = '{
        '{10'h2bc, 8'h14, 1'b0, 20},
        '{10'h29a, 8'h14, 1'b1, 20}, // knee
        '{10'h1d2, 8'h14, 1'b0, 24},
        '{10'h10a, 8'h14, 1'b1, 28}, // full extension
        '{10'h236, 8'h0a, 1'b0, 11},
        '{10'h000, 8'h0a, 1'b0, 14} // capped
    };
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [9:0] line = 10'h2bc;
    logic [7:0] tzmin = 8'h14;
    logic slow = 1'b0;
    logic dip = 1'b0;
    logic sw, zero_current_detect, hs, ls, settled;
    logic [7:0] ot_cnt, tdm_at;
    logic [7:0] ot [0:63];
    logic hs_p = 1'b0, ls_p = 1'b0, in_gap = 1'b0;
    int n_mismatch = 0, num_checks = 0, cyc = 0, nls = 0;
    int win = 0, gap = 0, zc = 0, ac = 0, z2h = 0, r2l = 0, hs_len = 0;

    always #10 clk = ~clk;

    zdt_core dut_u (
        .clk(clk), .reset(reset), .switch_node_sense_input(sw), .aux_sense_input(zero_current_detect),
        .line_sense_current(line), .window_program_pin(tzmin), .high_side_gate_cmd(hs),
        .low_side_gate_cmd(ls), .on_time_count(ot_cnt), .tune_settled(settled)
    );
    zdt_stage_model stage_u (
        .clk(clk), .reset(reset), .hs(hs), .ls(ls), .slow(slow), .dip(dip),
        .target(8'h14), .zero_current_detect(zero_current_detect), .sw(sw)
    );

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wait_ls(input int n);
        int t;
        t = nls + n;
        while (nls < t) @(negedge clk);
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // measures dead times, windows and on-times; cuts a hang short
    always @(posedge clk) begin
        cyc++;
        if (hs && !hs_p) begin
            z2h = zc;
            tdm_at = ot_cnt;
            hs_len = 0;
        end
        if (hs) hs_len++;
        if (!hs && hs_p) begin
            in_gap = 1'b1;
            gap = 0;
        end
        if (in_gap && !hs && !ls) gap++;
        if (ls && !ls_p) begin
            r2l = ac;
            if (in_gap) win = gap;
            in_gap = 1'b0;
            nls++;
            if (nls < 64) ot[nls] = ot_cnt;
        end
        zc = zero_current_detect ? 0 : zc + 1;
        ac = zero_current_detect ? ac + 1 : 0;
        hs_p = hs;
        ls_p = ls;
        if (cyc == 30000) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: run did not finish", $time);
            end_of_test();
        end
    end

    // main sequence: reset, tuning, row table, false transition
    initial begin
        repeat (4) @(negedge clk);
        chk(16'({hs, ls, ot_cnt, settled}), 16'h0000);
        reset = 1'b0;
        $display("reset test done");
        wait_ls(2);
        chk(16'(ot[1]), 16'h0000);
        chk(16'(ot[2]), 16'(STEP_COARSE));
        wait_ls(14);
        chk(16'(settled), 16'h0001);
        for (int i = 0; i < 2; i++) begin
            wait_ls(1);
            chk(16'((ot[nls] - ot[nls-1]) inside {8'h01, 8'hff}), 16'h0001);
            chk(16'(ot[nls] inside {[8'h12:8'h16]}), 16'h0001);
        end
        $display("tuning test done");
        foreach (rows[i]) begin
            line = rows[i].line;
            tzmin = rows[i].tzmin;
            slow = rows[i].slow;
            wait_ls(3);
            chk(16'(win), 16'(rows[i].tz));
            chk(16'(z2h), 16'h0003);
            chk(16'(hs_len), 16'(tdm_at));
            $display("row %0d done", i);
        end
        dip = 1'b1;
        wait_ls(1);
        chk(16'(win > rows[NROW-1].tz), 16'h0001);
        chk(16'(r2l), 16'h0003);
        dip = 1'b0;
        $display("false transition test done");
        end_of_test();
    end
endmodule

// [dv/zdt_stage_model.sv]
// power stage model: zcd ringing, high-side timing and switch-node check
module zdt_stage_model (
    input wire logic clk,
    input wire logic reset,
    input wire logic hs,
    input wire logic ls,
    input wire logic slow,
    input wire logic dip,
    input wire logic [7:0] target,
    output logic zero_current_detect,
    output logic sw
);
    timeunit 1ns;
    timeprecision 1ps;
    int n;
    int k;
    logic skip;
    // zcd falls after low side off, rises again once the high side ends, or after the 30-cycle valley ring when no high-side pulse came
    initial begin
        zero_current_detect = 1'b0;
        sw = 1'b0;
        skip = 1'b0;
        @(negedge clk iff !reset);
        forever begin
            if (!skip) repeat (30) @(negedge clk); // valley ring
            zero_current_detect = 1'b1;
            @(negedge clk iff ls);
            @(negedge clk iff !ls);
            repeat (slow ? 12 : 2) @(negedge clk); // slow or prompt demag
            zero_current_detect = 1'b0;
            n = 0;
            k = 0;
            while (!hs && k < 6) begin
                @(negedge clk);
                k++;
            end
            while (hs) begin
                @(negedge clk);
                n++;
            end
            skip = n > 0 && !dip;
            if (n > 0) begin
                @(negedge clk);
                sw = n >= int'(target); // enough negative current
                zero_current_detect = 1'b1;
                repeat (2) @(negedge clk);
                sw = 1'b0;
                zero_current_detect = !dip; // dip: false transition collapses early
            end
        end
    end
endmodule

// [hdl/zdt_core.sv]
// adaptive zvs on-time tuning and dead-time control
module zdt_core (
    input wire logic clk,
    input wire logic reset,
    input wire logic switch_node_sense_input,
    input wire logic aux_sense_input,
    input wire logic [zdt_pkg::LINE_W-1:0] line_sense_current,
    input wire logic [zdt_pkg::TZ_W-1:0] window_program_pin,
    output logic high_side_gate_cmd,
    output logic low_side_gate_cmd,
    output logic [zdt_pkg::TDM_W-1:0] on_time_count,
    output logic tune_settled
);
    import zdt_pkg::*;

    // ****************************************
    // pin synchronisation
    // ****************************************
    zdt_pins_t pins_raw;
    zdt_pins_t pins;
    logic [PINS_W-1:0] pins_q;

    assign pins_raw = '{sw_cross: switch_node_sense_input, aux_high: aux_sense_input,
                        line_ua: line_sense_current, tz_min: window_program_pin};

    zdt_sync #(.W(PINS_W)) u_sync (
        .clk(clk),
        .reset(reset),
        .d(pins_raw),
        .q(pins_q)
    );

    assign pins = zdt_pins_t'(pins_q);

    // ****************************************
    // transition window law
    // ****************************************
    zdt_core_t state_reg;
    zdt_core_t state_next;
    logic zero_current_detect;
    logic [PROD_W-1:0] diff;
    logic [PROD_W-1:0] ext;
    logic [PROD_W-1:0] cap;
    logic [PROD_W-1:0] tz_sum;
    logic [CNT_W-1:0] tz_cyc;

    assign zero_current_detect = pins.aux_high;

    // extension grows linearly below the knee, clipped at 40% of the minimum
    always_comb begin
        diff = '0;
        if (state_reg.line < LINE_SENSE_CURRENT_KNEE_UA) begin
            diff = PROD_W'(LINE_SENSE_CURRENT_KNEE_UA - state_reg.line);
        end
        ext = PROD_W'((PROD_W'(pins.tz_min) * diff) / EXT_DIV);
        cap = PROD_W'((PROD_W'(pins.tz_min) * EXT_NUM) / EXT_DEN);
        tz_sum = PROD_W'(pins.tz_min) + ((ext > cap) ? cap : ext);
        tz_cyc = (tz_sum == '0) ? CNT_W'(1) : CNT_W'(tz_sum);
    end

    // ****************************************
    // switching sequence and tuning loop
    // ****************************************
    logic tz_end;
    logic crossed_now;
    logic up;
    logic zcd_fall;
    logic zcd_rise;
    logic [TDM_W:0] tdm_up;
    logic [TDM_W:0] tdm_dn;
    logic [TDM_W:0] delta;

    assign zcd_fall = state_reg.zcd_d & ~zero_current_detect;
    assign zcd_rise = ~state_reg.zcd_d & zero_current_detect;
    // at or past the last window cycle, so a strap change mid-window cannot stall it
    assign tz_end = (state_reg.st == ST_TZ) && (state_reg.cnt >= tz_cyc - CNT_W'(1));
    assign crossed_now = state_reg.crossed | pins.sw_cross;
    assign up = ~crossed_now;

    always_comb begin
        state_next = state_reg;
        state_next.zcd_d = zero_current_detect;
        state_next.cnt = state_reg.cnt + CNT_W'(1);
        delta = state_reg.settled ? (TDM_W+1)'(STEP_LSB) : (TDM_W+1)'(state_reg.step);
        tdm_up = {1'b0, state_reg.tdm} + delta;
        tdm_dn = ({1'b0, state_reg.tdm} > delta) ? {1'b0, state_reg.tdm} - delta : '0;
        unique case (state_reg.st)
            ST_LS_ON: begin
                state_next.line = pins.line_ua;
                if (state_reg.cnt >= LS_ON_LAST) begin
                    state_next.st = ST_WAIT_FALL;
                end
            end
            ST_WAIT_FALL: begin
                // low-to-high dead time ends on zcd falling, for either switch type
                if (zcd_fall) begin
                    state_next.cnt = '0;
                    state_next.crossed = 1'b0;
                    // zero on-time means valley switching with no high-side pulse
                    state_next.st = (state_reg.tdm != '0) ? ST_HS_ON : ST_TZ;
                end
            end
            ST_HS_ON: begin
                if (state_reg.cnt >= CNT_W'(state_reg.tdm) - CNT_W'(1)) begin
                    state_next.cnt = '0;
                    state_next.st = ST_TZ;
                end
            end
            ST_TZ: begin
                state_next.crossed = crossed_now;
                if (tz_end) begin
                    // decision is held pending until the next cycle starts
                    state_next.tdm_pend = up ? ((tdm_up > (TDM_W+1)'(TDM_MAX)) ? TDM_MAX : tdm_up[TDM_W-1:0])
                                             : tdm_dn[TDM_W-1:0];
                    state_next.last_up = up;
                    if (!state_reg.settled) begin
                        state_next.cyc = state_reg.cyc + CYC_W'(1);
                        if (up != state_reg.last_up && state_reg.step > STEP_LSB) begin
                            state_next.step = state_reg.step >> 1;
                        end
                        if (state_reg.cyc == CYC_LAST ||
                            (up != state_reg.last_up && state_reg.step == STEP_LSB)) begin
                            state_next.settled = 1'b1;
                            state_next.step = STEP_LSB;
                        end
                    end
                    state_next.cnt = '0;
                    if (zero_current_detect) begin
                        state_next.st = ST_LS_ON;
                        state_next.tdm = state_next.tdm_pend;
                    end else begin
                        state_next.st = ST_WAIT_RISE;
                    end
                end
            end
            ST_WAIT_RISE: begin
                if (zcd_rise) begin
                    state_next.cnt = '0;
                    state_next.st = ST_LS_ON;
                    state_next.tdm = state_reg.tdm_pend;
                end
            end
            default: begin
                state_next.st = ST_WAIT_RISE;
            end
        endcase
        // gates follow the next state, so both are low through each dead time
        state_next.hs = (state_next.st == ST_HS_ON);
        state_next.ls = (state_next.st == ST_LS_ON) && (state_reg.st != ST_TZ || tz_end || state_reg.ls);
    end

    // state register
    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg <= '{st: ST_WAIT_RISE, cnt: '0, tdm: TDM_RESET, tdm_pend: TDM_RESET,
                           step: STEP_COARSE, last_up: 1'b1, settled: 1'b0, cyc: '0,
                           crossed: 1'b0, line: '0, zcd_d: 1'b0, hs: 1'b0, ls: 1'b0};
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs straight from the state register
    assign high_side_gate_cmd = state_reg.hs;
    assign low_side_gate_cmd = state_reg.ls;
    assign on_time_count = state_reg.tdm;
    assign tune_settled = state_reg.settled;

    // ****************************************
    // assertions
    // ****************************************
    sequence seq_zcd_fall_hs;
        (state_reg.st == ST_WAIT_FALL) && zcd_fall && (state_reg.tdm != '0);
    endsequence

    sequence seq_tz_expire;
        tz_end;
    endsequence

    AST_HS_AT_ZCD_FALL: assert property (@(posedge clk) disable iff (reset)
        seq_zcd_fall_hs |=> high_side_gate_cmd && !low_side_gate_cmd)
        else $error("high side not driven right after zcd fall");

    AST_NO_OVERLAP: assert property (@(posedge clk) disable iff (reset)
        !(high_side_gate_cmd && low_side_gate_cmd))
        else $error("both gates on together");

    AST_NO_LS_WITHOUT_ZCD: assert property (@(posedge clk) disable iff (reset)
        seq_tz_expire and !zero_current_detect |=> !low_side_gate_cmd && state_reg.st == ST_WAIT_RISE)
        else $error("low side turned on without valid zcd");

    AST_LS_ON_RISE: assert property (@(posedge clk) disable iff (reset)
        (state_reg.st == ST_WAIT_RISE) && zcd_rise |=> low_side_gate_cmd)
        else $error("low side not started on zcd rising edge");

    AST_UP_REQUEST: assert property (@(posedge clk) disable iff (reset)
        seq_tz_expire and !crossed_now and (state_reg.tdm != TDM_MAX) |=>
        state_reg.tdm_pend > $past(state_reg.tdm))
        else $error("missing increase request");

    AST_LSB_STEP: assert property (@(posedge clk) disable iff (reset)
        seq_tz_expire and state_reg.settled and (state_reg.tdm != TDM_MAX) and (state_reg.tdm != '0) |=>
        (state_reg.tdm_pend == $past(state_reg.tdm) + TDM_W'(1)) ||
        (state_reg.tdm_pend == $past(state_reg.tdm) - TDM_W'(1)))
        else $error("settled step is not one lsb");

    AST_SETTLE_BOUND: assert property (@(posedge clk) disable iff (reset)
        !tune_settled |-> state_reg.cyc <= CYC_LAST)
        else $error("tuning not settled within bound");

    AST_APPLY_NEXT: assert property (@(posedge clk) disable iff (reset)
        $changed(on_time_count) |-> state_reg.st == ST_LS_ON && $past(state_reg.st) != ST_LS_ON)
        else $error("on-time changed inside a cycle");

    AST_TZ_RANGE: assert property (@(posedge clk) disable iff (reset)
        (pins.tz_min != '0) |-> tz_cyc >= CNT_W'(pins.tz_min) &&
        PROD_W'(tz_cyc) * EXT_DEN <= PROD_W'(pins.tz_min) * (EXT_DEN + EXT_NUM))
        else $error("window outside 100 to 140 percent");

    AST_LINE_HOLD: assert property (@(posedge clk) disable iff (reset)
        state_reg.st != ST_LS_ON |=> $stable(state_reg.line))
        else $error("line current sampled outside low-side on");

    AST_TZ_ALL_LOW: assert property (@(posedge clk) disable iff (reset)
        state_reg.st == ST_TZ |-> !high_side_gate_cmd && !low_side_gate_cmd)
        else $error("gate on during transition window");
endmodule

// [hdl/zdt_pkg.sv]
// constants, types and state for the zvs tuning and dead-time block
// Functional notes
// - judge zvs by threshold crossing within window
// - no crossing: request longer high-side on-time
// - settled loop steps one lsb per cycle
// - valley switching first, settled within 15 cycles
// - control both high-low and low-high dead times
// - window grows linearly to 140% below 666 ua
// - sample line current while low side on
// - no valid zcd at expiry: wait rising edge
// - high side on right at zcd falling edge
// - same low-high dead time for both switch types
// - zcd and line data from aux sense input; code takes line data from line_sense_current
package zdt_pkg;

    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_NS = 20;
    localparam int LS_ON_NS = 1000; // fixed low-side conduction time
    localparam int LS_ON_CYC = (LS_ON_NS + CLK_NS - 1) / CLK_NS;
    localparam int SETTLE_CYCLES = 15; // switching cycles to settle

    // ****************************************
    // widths and tuning constants
    // ****************************************
    localparam int TDM_W = 8;
    localparam int LINE_W = 10;
    localparam int TZ_W = 8;
    localparam int CNT_W = 9;
    localparam int STEP_W = 4;
    localparam int CYC_W = 4;
    localparam int PROD_W = 18;
    localparam logic [STEP_W-1:0] STEP_COARSE = 4'h8;
    localparam logic [STEP_W-1:0] STEP_LSB = 4'h1;
    localparam logic [TDM_W-1:0] TDM_MAX = 8'hff;
    localparam logic [TDM_W-1:0] TDM_RESET = 8'h00;
    localparam logic [CYC_W-1:0] CYC_LAST = 4'he; // SETTLE_CYCLES - 1
    localparam logic [CNT_W-1:0] LS_ON_LAST = CNT_W'(LS_ON_CYC - 1);

    // ****************************************
    // transition window law
    // ****************************************
    localparam logic [LINE_W-1:0] LINE_SENSE_CURRENT_KNEE_UA = 10'h29a; // 666 ua
    localparam logic [PROD_W-1:0] EXT_DIV = 18'h003e8; // 400 ua span, 40% ext
    localparam logic [PROD_W-1:0] EXT_NUM = 18'h00002; // 140% cap = 2/5 extra
    localparam logic [PROD_W-1:0] EXT_DEN = 18'h00005;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [2:0] {
        ST_LS_ON = 3'h0,
        ST_WAIT_FALL = 3'h1,
        ST_HS_ON = 3'h2,
        ST_TZ = 3'h3,
        ST_WAIT_RISE = 3'h4
    } zdt_state_t;

    typedef struct packed {
        logic sw_cross;
        logic aux_high;
        logic [LINE_W-1:0] line_ua;
        logic [TZ_W-1:0] tz_min;
    } zdt_pins_t;

    localparam int PINS_W = $bits(zdt_pins_t);

    typedef struct packed {
        zdt_state_t st;
        logic [CNT_W-1:0] cnt;
        logic [TDM_W-1:0] tdm;
        logic [TDM_W-1:0] tdm_pend;
        logic [STEP_W-1:0] step;
        logic last_up;
        logic settled;
        logic [CYC_W-1:0] cyc;
        logic crossed;
        logic [LINE_W-1:0] line;
        logic zcd_d;
        logic hs;
        logic ls;
    } zdt_core_t;

endpackage

// [hdl/zdt_sync.sv]
// two-stage synchroniser for pin inputs
module zdt_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [1:0][W-1:0] state_reg;
    logic [1:0][W-1:0] state_next;

    // stage 0 feeds only stage 1
    always_comb begin
        state_next[0] = d;
        state_next[1] = state_reg[0];
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign q = state_reg[1];
endmodule
